// >>> hdl/rbcfg_defines.svh
// constants for the readback, refresh and gear configuration register
// assumes a single 20 MHz clock shared by controller and device
`ifndef RBCFG_DEFINES_SVH
`define RBCFG_DEFINES_SVH
// How it works
// - command lines map onto register bits 21..0
// - controller writes zero to bits 21,17,13
// - bits 12:11 pick readback read format
// - bits 10:9 pick crc/mask write latency
// - controller programs that latency with crc+mask
// - bits 8:6 pick refresh granularity
// - bit 5 keeps temperature status updated
// - temperature status never older than 32 ms
// - bit 4 lets each device mask register sets
// - bit 3 picks half or quarter rate
// - quarter rate needs register write then sync
// - bit 2 turns readback store reads on
// - bits 1:0 pick page, page 3 reserved
// - controller enters readback with banks idle
// - reads in readback go to store location
// - register contents read back in halves
// - only reads and writes during readback; controller also allows register sets and reset there
// - reset accepted in readback, then reinitialise
// - store holds registers, patterns, error frame

// register image layout
`define CFG_WIDTH 22
`define CFG_RESET 22'h000000
`define CFG_RSVD_MASK 22'h222000
`define CFG_SELECT 3'h3
`define FMT_LSB 11
`define WLAT_LSB 9
`define FGR_LSB 6
`define TEMP_BIT 5
`define PDA_BIT 4
`define GEAR_BIT 3
`define RB_BIT 2
`define PAGE_LSB 0

// timing
`define CLOCK_HZ 20000000
`define TEMP_AGE_MS 32
`define TEMP_CYCLES ((`TEMP_AGE_MS * `CLOCK_HZ) / 1000)
`define BURST_BEATS 8
`define SYNC_GAP 4'h3
`define RST_CYCLES 4'h4

// controller register word indexes on the avalon slave
`define REG_CFG 3'h0
`define REG_CMD 3'h1
`define REG_STATUS 3'h2
`define REG_RD_LO 3'h3
`define REG_RD_HI 3'h4
`define CMD_OP_LSB 28
`define SKIP_BIT 31
`endif

// >>> hdl/rbcfg_pkg.sv
// types shared by both ends of the configuration link
// assumes rbcfg_defines.svh for the numeric layout
package rbcfg_pkg;
    typedef enum logic [1:0] {
        FMT_SERIAL = 2'b00,
        FMT_PARALLEL = 2'b01,
        FMT_STAGGER = 2'b10
    } read_format_t;
    typedef enum logic [1:0] {
        OP_READ = 2'b00,
        OP_WRITE = 2'b01,
        OP_SYNC = 2'b10,
        OP_RESET = 2'b11
    } ctrl_op_t;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_SYNC = 2'b01,
        PH_READ = 2'b10,
        PH_RESET = 2'b11
    } phase_t;
    // pick one byte out of four packed bytes
    function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] i);
        byte_of = w[8*i +: 8];
    endfunction
    // true when any multi-bit field holds a reserved code
    function automatic logic has_reserved_code(input logic [21:0] v);
        has_reserved_code = (v[12:11] == 2'h3) || (v[10:9] == 2'h3) || (v[8:6] == 3'h3)
            || (v[8:6] == 3'h4) || (v[8:6] == 3'h7) || (v[1:0] == 2'h3);
    endfunction
endpackage

// >>> hdl/rbcfg_link_if.sv
// command/address and data lines between controller and device
// assumes both ends run on the same clock, no tristate lines
`timescale 1ns/1ns
interface rbcfg_link_if;
    logic reset_n;      // device reset, active low
    logic cs_n;         // command select, active low
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bg;     // bank group, carries image bits 21:20
    logic [1:0] ba;     // bank, carries image bits 19:18
    logic [17:0] addr;  // a17..a0, bits 16:14 unused
    logic sync;         // gear-down sync pulse
    logic [7:0] dq_wr;  // controller to device data
    logic [7:0] dq_rd;  // device to controller data
    logic dq_rd_valid;  // one beat of read burst
    modport ctrl (output reset_n, cs_n, ras_n, cas_n, we_n, bg, ba, addr, sync, dq_wr,
        input dq_rd, dq_rd_valid);
    modport dev (input reset_n, cs_n, ras_n, cas_n, we_n, bg, ba, addr, sync, dq_wr,
        output dq_rd, dq_rd_valid);
endinterface

// >>> hdl/rbcfg_burst.sv
// eight-beat read burst generator for the readback store
// assumes a start pulse with the four bytes of the selected page
`timescale 1ns/1ns
`include "rbcfg_defines.svh"
module rbcfg_burst
    import rbcfg_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_clk_en,
    input wire logic i_start,
    input wire logic [31:0] i_bytes,
    input wire logic [1:0] i_loc,
    input wire logic [1:0] i_format,
    output logic [7:0] o_dq,
    output logic o_valid
);
    typedef struct packed {
        logic busy;        // burst in progress
        logic [2:0] beat;  // beat being formed
        logic [31:0] bytes;
        logic [1:0] loc;
        logic [1:0] fmt;
        logic [7:0] dq;
        logic valid;
    } burst_t;
    burst_t s;
    burst_t next_s;
    logic [7:0] lane_byte; // byte feeding the lane being formed

    // form one beat per cycle; a new start mid-burst is not expected
    always_comb begin
        lane_byte = 8'h00;
        next_s = s;
        next_s.valid = 1'b0;
        if (i_start) begin
            next_s.busy = 1'b1;
            next_s.beat = 3'h0;
            next_s.bytes = i_bytes;
            next_s.loc = i_loc;
            next_s.fmt = i_format;
        end else if (s.busy) begin
            next_s.valid = 1'b1;
            case (s.fmt)
                FMT_PARALLEL: begin
                    next_s.dq = byte_of(s.bytes, s.loc);
                end
                FMT_STAGGER: begin
                    // lane j walks location loc+j, msb first
                    for (int j = 0; j < 8; j++) begin
                        lane_byte = byte_of(s.bytes, 2'(s.loc + 2'(j)));
                        next_s.dq[j] = lane_byte[3'h7 - s.beat];
                    end
                end
                default: begin
                    // serial, and the reserved code falls back to serial
                    lane_byte = byte_of(s.bytes, s.loc);
                    next_s.dq = {8{lane_byte[3'h7 - s.beat]}};
                end
            endcase
            next_s.beat = s.beat + 3'h1;
            if (s.beat == 3'(`BURST_BEATS - 1)) begin
                next_s.busy = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            s <= '0;
        end else if (i_clk_en) begin
            s <= next_s;
        end
    end

    assign o_dq = s.dq;
    assign o_valid = s.valid;
endmodule

// >>> hdl/rbcfg_device.sv
// device end: decodes register writes for the readback, refresh and gear
// configuration register and serves the readback store
// assumes the controller shares i_clock and drives the link modport
`timescale 1ns/1ns
`include "rbcfg_defines.svh"
module rbcfg_device
    import rbcfg_pkg::*;
#(
    parameter int TEMP_CYCLES = `TEMP_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_clk_en,
    input wire logic [1:0] i_temp_sensor,
    input wire logic [31:0] i_error_frame,
    rbcfg_link_if.dev link,
    output logic [21:0] o_cfg,
    output logic o_readback_on,
    output logic [1:0] o_read_format,
    output logic [2:0] o_write_latency,
    output logic [2:0] o_refresh_mode,
    output logic o_temp_report_on,
    output logic o_per_device_on,
    output logic o_quarter_rate,
    output logic [1:0] o_temp_status
);
    typedef struct packed {
        logic [21:0] cfg;       // stored register image
        logic [1:0] fmt;        // last valid read format
        logic [2:0] wlat;       // write latency in clocks
        logic [2:0] fgr;        // last valid refresh mode
        logic quarter;          // quarter-rate clocking active
        logic gear_pend;        // waiting for the sync pulse
        logic [1:0] temp;       // reported temperature status
        logic [19:0] tcnt;      // cycles to the next status update
        logic [31:0] pat;       // calibration pattern bytes, page 0
        logic [1:0] ts1;        // sensor synchroniser stages
        logic [1:0] ts2;
        logic [1:0] ts3;
        logic [1:0] tin;        // sensor value after agreement
    } dev_t;
    dev_t s;
    dev_t next_s;

    logic cmd_on;         // a command is on the lines this cycle
    logic is_cfg_write;   // register set aimed at this register
    logic is_read;
    logic is_write;
    logic pda_pass;       // command not masked off for this device
    logic [21:0] image;   // register image assembled from the lines
    logic [31:0] page_bytes;
    logic rst_all;        // board reset or link reset
    logic burst_start;

    // command decode from the link lines
    always_comb begin
        cmd_on = !link.cs_n;
        // bank group, bank and address lines form the image
        image = {link.bg, link.ba, link.addr[17], 3'h0, link.addr[13:0]};
        // select field 20:18 must name this register, with strobes all low
        is_cfg_write = cmd_on && !link.ras_n && !link.cas_n && !link.we_n
            && ({link.bg[0], link.ba} == `CFG_SELECT);
        is_read = cmd_on && link.ras_n && !link.cas_n && link.we_n;
        is_write = cmd_on && link.ras_n && !link.cas_n && !link.we_n;
        // with per-device addressing on, dq0 high masks the command off
        pda_pass = !s.cfg[`PDA_BIT] || !link.dq_wr[0];
    end

    // readback store pages; page 3 belongs to the maker and reads as zero
    always_comb begin
        case (s.cfg[`PAGE_LSB +: 2])
            2'h0: begin
                page_bytes = s.pat;
            end
            2'h1: begin
                page_bytes = i_error_frame;
            end
            2'h2: begin
                // location 0 temperature, then the register image in three bytes at locations 1 to 3
                page_bytes = {2'h0, s.cfg[21:16], s.cfg[15:8], s.cfg[7:0],
                    3'h0, s.temp, 3'h0};
            end
            default: begin
                page_bytes = 32'h00000000;
            end
        endcase
    end

    // reads go to the store only while readback is on
    assign burst_start = is_read && s.cfg[`RB_BIT];
    // a link reset clears everything, even in the middle of readback
    assign rst_all = !i_rstn || !link.reset_n;

    // next-state logic for configuration, gear, store and temperature
    always_comb begin
        next_s = s;
        // register set: reserved bits are dropped if the controller slips
        if (is_cfg_write && pda_pass) begin
            next_s.cfg = image & ~`CFG_RSVD_MASK;
            // reserved format, latency and refresh codes leave the previous working setting in place
            if (image[`FMT_LSB +: 2] != 2'h3) begin
                next_s.fmt = image[`FMT_LSB +: 2];
            end
            case (image[`WLAT_LSB +: 2])
                2'h0: begin
                    next_s.wlat = 3'h4;
                end
                2'h1: begin
                    next_s.wlat = 3'h5;
                end
                2'h2: begin
                    next_s.wlat = 3'h6;
                end
                default: begin
                    next_s.wlat = s.wlat;
                end
            endcase
            case (image[`FGR_LSB +: 3])
                3'h0, 3'h1, 3'h2, 3'h5, 3'h6: begin
                    next_s.fgr = image[`FGR_LSB +: 3];
                end
                default: begin
                    next_s.fgr = s.fgr;
                end
            endcase
            // quarter rate is armed here and only taken at the sync pulse
            if (image[`GEAR_BIT] && !s.quarter) begin
                next_s.gear_pend = 1'b1;
            end else if (!image[`GEAR_BIT]) begin
                next_s.quarter = 1'b0;
                next_s.gear_pend = 1'b0;
            end
        end
        // sync pulse aligns the slow command sampling
        if (link.sync && s.gear_pend) begin
            next_s.quarter = 1'b1;
            next_s.gear_pend = 1'b0;
        end
        // pattern writes land at the location given by the address
        if (is_write && s.cfg[`RB_BIT] && (s.cfg[`PAGE_LSB +: 2] == 2'h0)) begin
            next_s.pat[8*link.addr[1:0] +: 8] = link.dq_wr;
        end
        // sensor synchroniser; the value counts once stages two and three agree
        next_s.ts1 = i_temp_sensor;
        next_s.ts2 = s.ts1;
        next_s.ts3 = s.ts2;
        if (s.ts2 == s.ts3) begin
            next_s.tin = s.ts3;
        end
        // status refresh: counter held at zero while off, so enabling
        // updates at once and then at least every period
        if (!s.cfg[`TEMP_BIT]) begin
            next_s.tcnt = 20'h00000;
        end else if (s.tcnt == 20'h00000) begin
            next_s.temp = s.tin;
            next_s.tcnt = 20'(TEMP_CYCLES - 1);
        end else begin
            next_s.tcnt = s.tcnt - 20'h00001;
        end
    end

    // state register; the link reset acts like the board reset
    always_ff @(posedge i_clock) begin
        if (rst_all) begin
            s <= '0;
        end else if (i_clk_en) begin
            s <= next_s;
        end
    end

    // read bursts from the store
    rbcfg_burst u_burst (
        .i_clock(i_clock),
        .i_rstn(!rst_all),
        .i_clk_en(i_clk_en),
        .i_start(burst_start),
        .i_bytes(page_bytes),
        .i_loc(link.addr[1:0]),
        .i_format(s.fmt),
        .o_dq(link.dq_rd),
        .o_valid(link.dq_rd_valid)
    );

    // user-side view of the decoded configuration
    assign o_cfg = s.cfg;
    assign o_readback_on = s.cfg[`RB_BIT];
    assign o_read_format = s.fmt;
    assign o_write_latency = s.wlat;
    assign o_refresh_mode = s.fgr;
    assign o_temp_report_on = s.cfg[`TEMP_BIT];
    assign o_per_device_on = s.cfg[`PDA_BIT];
    assign o_quarter_rate = s.quarter;
    assign o_temp_status = s.temp;
endmodule

// >>> hdl/rbcfg_ctrl.sv
// controller end: software writes orders over avalon-mm, this end drives
// the link and collects read bursts
// assumes the device shares i_clock
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "rbcfg_defines.svh"
module rbcfg_ctrl
    import rbcfg_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_clk_en,
    input wire logic [2:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    rbcfg_link_if.ctrl link
);
    typedef struct packed {
        phase_t phase;
        logic [3:0] wcnt;       // wait counter for sync and reset
        logic [21:0] shadow;    // last image written
        logic rb_on;            // readback mode entered
        logic quarter;          // quarter rate entered
        logic refused;          // last order refused
        logic [2:0] beat;       // read beats collected
        logic [63:0] rdata;     // collected burst, first beat on top
        logic ack;              // answering the bus this cycle
        logic wait_rq;          // waitrequest, registered
        logic [31:0] rd;        // registered read data
        logic cmd;              // link command strobes, active high
        logic ras;
        logic cas;
        logic we;
        logic [1:0] bg;
        logic [1:0] ba;
        logic [17:0] addr;
        logic sync;
        logic [7:0] dq;
        logic link_rst;
    } ctrl_t;
    ctrl_t s;
    ctrl_t next_s;
    logic [21:0] img;

    // bus answers, order decode and link sequencing
    always_comb begin
        next_s = s;
        next_s.cmd = 1'b0;
        next_s.ras = 1'b0;
        next_s.cas = 1'b0;
        next_s.we = 1'b0;
        next_s.sync = 1'b0;
        next_s.ack = 1'b0;
        // reserved bits and the select field are forced
        img = i_avs_writedata[21:0] & ~`CFG_RSVD_MASK;
        img[20:18] = `CFG_SELECT;
        if (i_avs_read && !s.ack) begin
            next_s.ack = 1'b1;
            case (i_avs_address)
                `REG_CFG: next_s.rd = {10'h000, s.shadow};
                `REG_STATUS: next_s.rd = {28'h0000000, s.refused, s.quarter, s.rb_on, s.phase != PH_IDLE};
                `REG_RD_LO: next_s.rd = s.rdata[31:0];
                `REG_RD_HI: next_s.rd = s.rdata[63:32];
                default: next_s.rd = 32'h00000000;
            endcase
        end else if (i_avs_write && !s.ack && s.phase == PH_IDLE) begin
            // writes stall on waitrequest until the link is idle
            next_s.ack = 1'b1;
            next_s.refused = 1'b0;
            if (i_avs_address == `REG_CFG) begin
                if (has_reserved_code(img)) begin
                    next_s.refused = 1'b1;
                end else begin
                    // register set: all strobes low on the pins
                    next_s.cmd = 1'b1;
                    next_s.ras = 1'b1;
                    next_s.cas = 1'b1;
                    next_s.we = 1'b1;
                    {next_s.bg, next_s.ba} = img[21:18];
                    next_s.addr = {img[17], 3'h0, img[13:0]};
                    next_s.dq = {7'h00, i_avs_writedata[`SKIP_BIT]};
                    next_s.shadow = img;
                    // this end never opens a bank, so all banks are idle here
                    next_s.rb_on = img[`RB_BIT];
                    if (img[`GEAR_BIT] && !s.quarter) begin
                        next_s.phase = PH_SYNC;
                        next_s.wcnt = `SYNC_GAP;
                    end else if (!img[`GEAR_BIT]) begin
                        next_s.quarter = 1'b0;
                    end
                end
            end else if (i_avs_address == `REG_CMD) begin
                next_s.addr = {16'h0000, i_avs_writedata[1:0]};
                case (ctrl_op_t'(i_avs_writedata[`CMD_OP_LSB +: 2]))
                    OP_READ: begin
                        if (!s.rb_on) begin
                            next_s.refused = 1'b1;
                        end else begin
                            next_s.cmd = 1'b1;
                            next_s.cas = 1'b1;
                            next_s.phase = PH_READ;
                            next_s.beat = 3'h0;
                        end
                    end
                    OP_WRITE: begin
                        if (!s.rb_on) begin
                            next_s.refused = 1'b1;
                        end else begin
                            next_s.cmd = 1'b1;
                            next_s.cas = 1'b1;
                            next_s.we = 1'b1;
                            next_s.dq = i_avs_writedata[15:8];
                        end
                    end
                    OP_SYNC: begin
                        next_s.refused = s.rb_on;
                        next_s.sync = !s.rb_on;
                    end
                    default: begin
                        // reset is allowed in any mode, readback included, once the link is idle, and forgets all setup
                        next_s.link_rst = 1'b1;
                        next_s.phase = PH_RESET;
                        next_s.wcnt = `RST_CYCLES - 4'h1;
                        next_s.shadow = `CFG_RESET;
                        next_s.rb_on = 1'b0;
                        next_s.quarter = 1'b0;
                    end
                endcase
            end
        end
        case (s.phase)
            PH_SYNC: begin
                // low-rate gap after the register set, then the sync pulse
                next_s.wcnt = s.wcnt - 4'h1;
                if (s.wcnt == 4'h0) begin
                    next_s.sync = 1'b1;
                    next_s.quarter = 1'b1;
                    next_s.phase = PH_IDLE;
                end
            end
            PH_READ: begin
                if (link.dq_rd_valid) begin
                    next_s.rdata = {s.rdata[55:0], link.dq_rd};
                    next_s.beat = s.beat + 3'h1;
                    if (s.beat == 3'(`BURST_BEATS - 1)) begin
                        next_s.phase = PH_IDLE;
                    end
                end
            end
            PH_RESET: begin
                next_s.wcnt = s.wcnt - 4'h1;
                if (s.wcnt == 4'h0) begin
                    next_s.link_rst = 1'b0;
                    next_s.phase = PH_IDLE;
                end
            end
            default: begin
                next_s.phase = next_s.phase;
            end
        endcase
        next_s.wait_rq = !next_s.ack;
    end

    // state register
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            s <= '0;
        end else if (i_clk_en) begin
            s <= next_s;
        end
    end

    // link pins are active low where the protocol says so
    assign link.reset_n = !s.link_rst;
    assign link.cs_n = !s.cmd;
    assign link.ras_n = !s.ras;
    assign link.cas_n = !s.cas;
    assign link.we_n = !s.we;
    assign link.bg = s.bg;
    assign link.ba = s.ba;
    assign link.addr = s.addr;
    assign link.sync = s.sync;
    assign link.dq_wr = s.dq;
    assign o_avs_readdata = s.rd;
    assign o_avs_waitrequest = s.wait_rq;
endmodule

// >>> verif/rbcfg_link_sva.sv
// assertions on the link between the controller and device ends
// assumes the bench instantiates it beside the link, one clock
`timescale 1ns/1ns
module rbcfg_link_sva (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bg,
    input wire logic [1:0] ba,
    input wire logic [17:0] addr,
    input wire logic sync,
    input wire logic [7:0] dq_wr,
    input wire logic [7:0] dq_rd,
    input wire logic dq_rd_valid
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    // register set and read command decodes
    wire mrs = !cs_n && !ras_n && !cas_n && !we_n;
    wire rdc = !cs_n && ras_n && !cas_n && we_n;
    property p_map; mrs |-> {bg, ba} == 4'h3 && addr[16:14] == 3'h0; endproperty
    a_map: assert property (p_map) else $error("register set select wrong");
    property p_rsvd; mrs |-> !addr[17] && !addr[13]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit sent as one");
    // a reserved code in any field must never leave the controller
    property p_code; mrs |-> addr[12:11] != 2'h3 && addr[10:9] != 2'h3 && addr[1:0] != 2'h3
        && !(addr[8:6] inside {3'h3, 3'h4, 3'h7}); endproperty
    a_code: assert property (p_code) else $error("reserved field code sent");
    property p_start; rdc |-> ##[2:3] dq_rd_valid; endproperty
    a_start: assert property (p_start) else $error("read burst missing");
    property p_len; $rose(dq_rd_valid) |-> dq_rd_valid [*8] ##1 !dq_rd_valid; endproperty
    a_len: assert property (p_len) else $error("burst not eight beats");
    property p_sync; sync |=> !sync; endproperty
    a_sync: assert property (p_sync) else $error("sync longer than a cycle");
    property p_gear; mrs && addr[3] |-> ##4 sync; endproperty
    a_gear: assert property (p_gear) else $error("no sync after gear set");
    property p_rst; $fell(reset_n) |-> !reset_n [*4] ##1 reset_n; endproperty
    a_rst: assert property (p_rst) else $error("reset pulse length wrong");
    // while the device is held in reset nothing else is sent
    property p_quiet; !reset_n |-> cs_n && !sync; endproperty
    a_quiet: assert property (p_quiet) else $error("command during reset");
    c_burst: cover property ($rose(dq_rd_valid));
    c_sync: cover property (sync);
    c_rst: cover property ($fell(reset_n));
endmodule

// >>> verif/ddr_mode_reg3_mpr_control_bench.sv
// bench: software orders over avalon, device decode and readback checked
// assumes both design ends and the link checker compile first
`timescale 1ns/1ns
`include "rbcfg_defines.svh"
module ddr_mode_reg3_mpr_control_bench;
    import rbcfg_pkg::*;
    logic i_clock = 1'h0;
    logic i_rstn = 1'h0;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic [2:0] adr = 3'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] q;
    logic [31:0] err_frame = 32'hC3A5965A; // fixed error frame pattern
    logic [21:0] v;
    logic [1:0] f;
    logic [2:0] g;
    int err_count = 0;
    int comparisons = 0;
    wire [31:0] rdata;
    wire wait_req, rb_on, temp_on, pda_on, quarter;
    wire [21:0] cfg;
    wire [1:0] fmt_o, temp_o;
    wire [2:0] wlat_o, fgr_o;
    rbcfg_link_if link();
    rbcfg_ctrl rbcfg_ctrl_i(.i_clock, .i_rstn, .i_clk_en(1'h1), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .link(link));
    // short temperature period keeps the run brief
    rbcfg_device #(.TEMP_CYCLES(50)) rbcfg_device_i(.i_clock, .i_rstn, .i_clk_en(1'h1), .i_temp_sensor(2'h2),
        .i_error_frame(err_frame), .link(link), .o_cfg(cfg), .o_readback_on(rb_on), .o_read_format(fmt_o),
        .o_write_latency(wlat_o), .o_refresh_mode(fgr_o), .o_temp_report_on(temp_on), .o_per_device_on(pda_on),
        .o_quarter_rate(quarter), .o_temp_status(temp_o));
    rbcfg_link_sva rbcfg_link_sva_i(.i_clock, .i_rstn, .reset_n(link.reset_n), .cs_n(link.cs_n), .ras_n(link.ras_n),
        .cas_n(link.cas_n), .we_n(link.we_n), .bg(link.bg), .ba(link.ba), .addr(link.addr), .sync(link.sync),
        .dq_wr(link.dq_wr), .dq_rd(link.dq_rd), .dq_rd_valid(link.dq_rd_valid));
    always #25 i_clock = ~i_clock;
    // one avalon access; request held until the rising edge that sees waitrequest low,
    // data taken and request dropped at that same edge
    task automatic acc(input logic w, input logic [2:0] a, input logic [31:0] d);
        @(posedge i_clock);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge i_clock); while (wait_req !== 1'h0);
        q = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    // poll status until the link sequence is over
    task automatic idle();
        do acc(1'h0, `REG_STATUS, 32'h0); while (q[0] !== 1'h0);
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // read order then both halves of the collected burst
    task automatic rb_read(input logic [1:0] loc, input logic [7:0] b);
        acc(1'h1, `REG_CMD, {30'h0, loc});
        idle();
        acc(1'h0, `REG_RD_LO, 32'h0);
        cmp("burst_lo", {4{b}}, q);
        acc(1'h0, `REG_RD_HI, 32'h0);
        cmp("burst_hi", {4{b}}, q);
    endtask
    task automatic results();
        if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge i_clock);
        err_count++;
        results();
    end
    initial begin
        repeat (12) @(posedge i_clock);
        i_rstn <= 1'h1;
        acc(1'h0, `REG_STATUS, 32'h0);
        cmp("status", 32'h0, q);
        // every valid format, latency and refresh code, reserved bits written as one
        for (int i = 0; i < 5; i++) begin
            f = 2'(i % 3);
            g = (i < 3) ? 3'(i) : 3'(i + 2);
            v = {9'h111, f, f, g, i[0], i[1], 4'h0};
            acc(1'h1, `REG_CFG, {10'h0, v});
            idle();
            cmp("cfg", v & 22'h01DFFF, cfg & 22'h23FFFF);
            cmp("fields", {f, 3'(f) + 3'h4, g, i[0], i[1]}, {fmt_o, wlat_o, fgr_o, temp_on, pda_on});
        end
        acc(1'h1, `REG_CFG, 32'h1800);
        idle();
        cmp("status", 32'h8, q);
        cmp("cfg", v & 22'h01DFFF, cfg & 22'h23FFFF);
        acc(1'h1, `REG_CFG, 32'h8);
        idle();
        cmp("quarter", 32'h1, quarter);
        acc(1'h1, `REG_CFG, 32'h0);
        idle();
        cmp("quarter", 32'h0, quarter);
        acc(1'h1, `REG_CFG, 32'h826);
        idle();
        cmp("status", 32'h2, q);
        rb_read(2'h1, 8'h26);
        rb_read(2'h0, 8'h10);
        cmp("temp", 32'h2, temp_o);
        acc(1'h1, `REG_CFG, 32'h825);
        idle();
        rb_read(2'h2, err_frame[23:16]);
        acc(1'h1, `REG_CMD, 32'h20000000);
        idle();
        cmp("status", 32'hA, q);
        acc(1'h1, `REG_CMD, 32'h30000000);
        idle();
        cmp("cfg", 32'h0, {rb_on, cfg});
        results();
    end
endmodule
